// ===== bus_wait_ctrl.sv
// What this block does
// R1: A waiting device holds the clock low; next byte starts once both released.
// R2: Data phase: interrupt and wait at clock 8 fall, or 9 with timing bit set.
// R3: Master address phase: interrupt and wait at clock 9 fall, timing bit ignored.
// R4: Slave address phase: interrupt and wait at clock 9 only on own-address match.
// R5: Own-address match: slave drives acknowledge whatever the ack-enable bit says.
// R6: Slave receiving an extension code raises the interrupt at clock 8 fall.
// R7: Unmatched address after repeated start: interrupt at clock 9, no wait.
// R8: Address matching neither own nor extension, without repeated start: no interrupt and no wait.
// R9: Receiver and transmitter both leave wait on release bit or shift write.
// R10: Master also leaves wait on start or stop trigger; slave cannot.
// R11: With eight-clock wait, software fixes ack-enable before releasing the wait.
// R12: Every byte interrupt and wait entry is tied to a serial clock falling edge; the stop interrupt is not.
// R13: A stop condition on the bus raises the bus interrupt when stop-irq-enable is set.
// R14: Line data is captured into the shift register even while transmitting.
// R15: Stop interrupt only with stop-irq-enable set; stop flag set regardless.
// R16: Nine-clock wait with ack-enable set drives acknowledge from clock 8 fall.
// R17: Wait release lets go of the clock line so the pull-up raises it.
`timescale 1ns/10ps
module bus_wait_ctrl
	import bus_wait_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	output logic            bus_event_interrupt
);
	import bus_wait_pkg::*;

	logic              scl_s;
	logic              sda_s;
	logic              scl_d_ff;
	logic              sda_d_ff;
	logic [7:0]        ctrl_ff;
	logic [7:0]        shift_ff;
	logic [7:0]        own_ff;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  mask_ff;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  nxt_irq_stat;
	logic [7:0]        rdata_ff;
	logic [3:0]        rise_no_ff;
	phase_e            phase_ff;
	logic              busy_ff;
	logic              restart_ff;
	logic              sel_ff;
	logic              trc_ff;
	logic              exc_ff;
	logic              ack_rx_ff;
	logic              stop_flag_ff;
	logic              rx8_wait_ff;
	logic              rel_pend_ff;
	logic              scl_oe_n_ff;
	logic              sda_oe_n_ff;
	logic              irq_out_ff;
	logic              own_hit;
	logic              ext_hit;
	logic [7:0]        stat_w;
	logic [7:0]        rd_mux;

	line_sync3 u_scl_sync
	(
		.mclk       (mclk),
		.arst_n     (arst_n),
		.line_in    (scl_in),
		.line_level (scl_s)
	);

	line_sync3 u_sda_sync
	(
		.mclk       (mclk),
		.arst_n     (arst_n),
		.line_in    (sda_in),
		.line_level (sda_s)
	);

	addr_classify u_addr_classify
	(
		.rx_byte  (shift_ff),
		.own_addr (own_ff),
		.own_hit  (own_hit),
		.ext_hit  (ext_hit)
	);

	// Line events
	wire scl_rise  = scl_s & ~scl_d_ff;
	wire scl_fall  = ~scl_s & scl_d_ff;
	wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// Register decode
	wire wr_ctrl  = wr_en & (addr == CTRL_OFS);
	wire wr_shift = wr_en & (addr == SHIFT_OFS);
	wire wr_own   = wr_en & (addr == OWN_OFS);
	wire wr_mask  = wr_en & (addr == IRQ_MASK_OFS);
	wire rd_irq   = rd_en & (addr == IRQ_STAT_OFS);

	wire is_master  = ctrl_ff[MASTER_BIT];
	wire wait_tim9  = ctrl_ff[WAIT_TIM_BIT];
	wire in_wait    = ~scl_oe_n_ff;
	wire ack_en_now = wr_ctrl ? wdata[ACK_EN_BIT] : ctrl_ff[ACK_EN_BIT];

	// Any shift write releases; FFH is the usual receive-side value [R9]
	wire rel_by_bit  = wr_ctrl & wdata[WAIT_REL_BIT];
	wire rel_by_trig = wr_ctrl & is_master & (wdata[START_TRIG_BIT] | wdata[STOP_TRIG_BIT]); // [R10]
	wire wait_rel    = in_wait & (wr_shift | rel_by_bit | rel_by_trig); // [R9] [R10]

	wire fall8   = scl_fall & (rise_no_ff == CLK_LAST_DATA);
	wire fall9   = scl_fall & (rise_no_ff == CLK_ACK);
	wire ph_addr = (phase_ff == PH_ADDR);
	wire ph_data = (phase_ff == PH_DATA);
	wire involved = is_master | sel_ff;

	// Address phase timing; match is settled once eight bits are in
	wire slave_own  = ~is_master & own_hit;
	wire slave_ext  = ~is_master & ~own_hit & ext_hit;
	wire ext_ev8    = ph_addr & fall8 & slave_ext; // [R6]
	wire addr_wait9 = ph_addr & fall9 & (is_master | slave_own); // [R3] [R4]
	wire restart_miss = ph_addr & fall9 & ~is_master & ~own_hit & ~ext_hit & restart_ff; // [R7]

	// Data phase timing follows the wait-timing bit
	wire data_ev8 = ph_data & involved & fall8 & ~wait_tim9; // [R2]
	wire data_ev9 = ph_data & involved & fall9 & wait_tim9;  // [R2]

	// Every source is gated by a clock falling edge [R12]
	wire byte_ev  = ext_ev8 | addr_wait9 | restart_miss | data_ev8 | data_ev9; // [R8]
	wire wait_set = ext_ev8 | addr_wait9 | data_ev8 | data_ev9; // [R7] [R8]

	// Direction after the address byte, bit 0 is the direction bit
	wire addr_keep = is_master | own_hit | ext_hit;
	wire trc_next  = ph_addr ? (is_master ? ~shift_ff[0] : shift_ff[0]) : trc_ff;
	wire rx_ack16  = ph_data & involved & ~trc_ff & wait_tim9 & ctrl_ff[ACK_EN_BIT];

	assign irq_set[IRQ_BYTE_BIT] = byte_ev;
	assign irq_set[IRQ_STOP_BIT] = stop_det & ctrl_ff[STOP_IRQ_BIT]; // [R13] [R15]
	// Set wins over clear-on-read
	assign nxt_irq_stat = (irq_stat_ff & ~(rd_irq ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}})) | irq_set;

	assign stat_w[STAT_STOP_BIT]    = stop_flag_ff;
	assign stat_w[STAT_RESTART_BIT] = restart_ff;
	assign stat_w[STAT_WAIT_BIT]    = in_wait;
	assign stat_w[STAT_ACK_BIT]     = ack_rx_ff;
	assign stat_w[STAT_EXT_BIT]     = exc_ff;
	assign stat_w[STAT_TRC_BIT]     = trc_ff;
	assign stat_w[STAT_SEL_BIT]     = sel_ff;
	assign stat_w[STAT_BUSY_BIT]    = busy_ff;

	assign rd_mux = (addr == CTRL_OFS)     ? ctrl_ff :
	                (addr == STAT_OFS)     ? stat_w :
	                (addr == SHIFT_OFS)    ? shift_ff :
	                (addr == OWN_OFS)      ? own_ff :
	                (addr == IRQ_STAT_OFS) ? {6'h00, irq_stat_ff} :
	                (addr == IRQ_MASK_OFS) ? {6'h00, mask_ff} : 8'h00;

	// Line history and software registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_d_ff    <= 1'b1;
			sda_d_ff    <= 1'b1;
			ctrl_ff     <= CTRL_RST;
			own_ff      <= OWN_RST;
			mask_ff     <= MASK_RST;
			irq_stat_ff <= '0;
			rdata_ff    <= 8'h00;
			irq_out_ff  <= 1'b0;
		end
		else
		begin
			scl_d_ff    <= scl_s;
			sda_d_ff    <= sda_s;
			irq_stat_ff <= nxt_irq_stat;
			rdata_ff    <= rd_en ? rd_mux : 8'h00;
			// One cycle behind the status bits, kept registered for a clean pin
			irq_out_ff  <= |(irq_stat_ff & mask_ff);
			if (wr_ctrl)
				ctrl_ff <= wdata & CTRL_KEEP_MASK;
			if (wr_own)
				own_ff <= wdata;
			if (wr_mask)
				mask_ff <= wdata[IRQ_W-1:0];
		end
	end

	// Bit counter and shift register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rise_no_ff <= 4'h0;
			shift_ff   <= SHIFT_RST;
			ack_rx_ff  <= 1'b0;
		end
		else
		begin
			if (start_det || fall9)
				rise_no_ff <= 4'h0;
			else if (scl_rise && rise_no_ff < CLK_ACK)
				rise_no_ff <= rise_no_ff + 4'h1;
			// A software write beats a capture in the same cycle
			if (wr_shift)
				shift_ff <= wdata;
			else if (scl_rise && rise_no_ff < CLK_LAST_DATA && phase_ff != PH_IDLE)
				shift_ff <= {shift_ff[6:0], sda_s}; // [R14]
			if (scl_rise && rise_no_ff == CLK_LAST_DATA && trc_ff)
				ack_rx_ff <= ~sda_s;
		end
	end

	// Phase, role and flags
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_ff     <= PH_IDLE;
			busy_ff      <= 1'b0;
			restart_ff   <= 1'b0;
			sel_ff       <= 1'b0;
			trc_ff       <= 1'b0;
			exc_ff       <= 1'b0;
			stop_flag_ff <= 1'b0;
		end
		else if (stop_det)
		begin
			phase_ff     <= PH_IDLE;
			busy_ff      <= 1'b0;
			sel_ff       <= 1'b0;
			trc_ff       <= 1'b0;
			stop_flag_ff <= 1'b1; // [R15]
		end
		else if (start_det)
		begin
			phase_ff     <= PH_ADDR;
			busy_ff      <= 1'b1;
			restart_ff   <= busy_ff;
			sel_ff       <= 1'b0;
			exc_ff       <= 1'b0;
			trc_ff       <= is_master;
			stop_flag_ff <= 1'b0;
		end
		else
		begin
			if (ext_ev8)
				exc_ff <= 1'b1;
			if (ph_addr && fall9)
			begin
				phase_ff <= addr_keep ? PH_DATA : PH_IDLE; // [R8]
				sel_ff   <= ~is_master & (own_hit | ext_hit);
				trc_ff   <= addr_keep & trc_next;
			end
		end
	end

	// Clock stretch; the shared low line keeps both ends in step [R1]
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_oe_n_ff <= 1'b1;
			rx8_wait_ff <= 1'b0;
			rel_pend_ff <= 1'b0;
		end
		else if (stop_det || start_det || rel_pend_ff || (wait_rel && !rx8_wait_ff))
		begin
			scl_oe_n_ff <= 1'b1; // [R17]
			rx8_wait_ff <= 1'b0;
			rel_pend_ff <= 1'b0;
		end
		else if (wait_rel)
			// Ack settles a cycle before the clock goes, so data never moves under a high clock
			rel_pend_ff <= 1'b1; // [R11]
		else if (wait_set)
		begin
			scl_oe_n_ff <= 1'b0; // [R1] [R12]
			rx8_wait_ff <= data_ev8 & ~trc_ff;
		end
	end

	// Data line drive
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sda_oe_n_ff <= 1'b1;
		else if (stop_det || start_det)
			sda_oe_n_ff <= 1'b1;
		else if (wr_shift && trc_ff && rise_no_ff == 4'h0)
			sda_oe_n_ff <= wdata[7];
		else if (wait_rel && rx8_wait_ff)
			sda_oe_n_ff <= ~ack_en_now; // [R11]
		else if (fall8)
			sda_oe_n_ff <= ~((ph_addr & slave_own) | rx_ack16); // [R5] [R16]
		else if (fall9)
			sda_oe_n_ff <= ~(addr_keep | ph_data) | ~trc_next | shift_ff[7];
		else if (scl_fall && trc_ff && rise_no_ff < CLK_LAST_DATA)
			sda_oe_n_ff <= shift_ff[7];
	end

	assign rdata               = rdata_ff;
	assign scl_out             = 1'b0;
	assign sda_out             = 1'b0;
	assign scl_oe_n            = scl_oe_n_ff;
	assign sda_oe_n            = sda_oe_n_ff;
	assign bus_event_interrupt = irq_out_ff;
endmodule

// ===== bus_wait_pkg.sv
package bus_wait_pkg;

	// Register offsets on the plain register port
	localparam logic [2:0] CTRL_OFS     = 3'h0;
	localparam logic [2:0] STAT_OFS     = 3'h1;
	localparam logic [2:0] SHIFT_OFS    = 3'h2;
	localparam logic [2:0] OWN_OFS      = 3'h3;
	localparam logic [2:0] IRQ_STAT_OFS = 3'h4;
	localparam logic [2:0] IRQ_MASK_OFS = 3'h5;

	// Bus control register fields
	localparam int STOP_TRIG_BIT  = 0;
	localparam int START_TRIG_BIT = 1;
	localparam int ACK_EN_BIT     = 2;
	localparam int WAIT_TIM_BIT   = 3;
	localparam int STOP_IRQ_BIT   = 4;
	localparam int WAIT_REL_BIT   = 5;
	localparam int MASTER_BIT     = 6;
	// Trigger bits are not stored and read back as zero
	localparam logic [7:0] CTRL_KEEP_MASK = 8'h5c;

	// Status register fields
	localparam int STAT_STOP_BIT    = 0;
	localparam int STAT_RESTART_BIT = 1;
	localparam int STAT_WAIT_BIT    = 2;
	localparam int STAT_ACK_BIT     = 3;
	localparam int STAT_EXT_BIT     = 4;
	localparam int STAT_TRC_BIT     = 5;
	localparam int STAT_SEL_BIT     = 6;
	localparam int STAT_BUSY_BIT    = 7;

	// Interrupt status and mask fields
	localparam int IRQ_BYTE_BIT = 0;
	localparam int IRQ_STOP_BIT = 1;
	localparam int IRQ_W        = 2;

	// Reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] SHIFT_RST = 8'hff;
	localparam logic [7:0] OWN_RST   = 8'h00;
	localparam logic [1:0] MASK_RST  = 2'h0;

	// Serial clock numbers within one byte
	localparam logic [3:0] CLK_LAST_DATA = 4'h8;
	localparam logic [3:0] CLK_ACK       = 4'h9;

	// Upper nibbles that mark an extension code
	localparam logic [3:0] EXT_HI_LOW  = 4'h0;
	localparam logic [3:0] EXT_HI_HIGH = 4'hf;

	typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} phase_e;

endpackage

// ===== line_sync3.sv
`timescale 1ns/10ps
module line_sync3
(
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic line_in,
	output logic      line_level
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// Idle bus level is high, so reset to one
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_ff      <= 1'b1;
			s2_ff      <= 1'b1;
			s3_ff      <= 1'b1;
			line_level <= 1'b1;
		end
		else
		begin
			s1_ff <= line_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			// Change is taken only once two stages agree
			if (s2_ff == s3_ff)
				line_level <= s3_ff;
		end
	end
endmodule

// ===== addr_classify.sv
`timescale 1ns/10ps
module addr_classify
	import bus_wait_pkg::*;
(
	input  wire logic [7:0] rx_byte,
	input  wire logic [7:0] own_addr,
	output logic            own_hit,
	output logic            ext_hit
);
	// Address sits in the upper seven bits, direction in bit 0
	assign own_hit = (rx_byte[7:1] == own_addr[7:1]);
	assign ext_hit = (rx_byte[7:4] == EXT_HI_LOW) || (rx_byte[7:4] == EXT_HI_HIGH);
endmodule

// ===== bus_wait_ctrl_assertions.sv
`timescale 1ns/10ps
module bus_wait_ctrl_assertions
	import bus_wait_pkg::*;
(
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe_n,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic       bus_event_interrupt
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic role_master_ff;
	// Role as stored before the write under test; triggers follow the old role
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			role_master_ff <= 1'b0;
		else if (wr_en && addr == CTRL_OFS)
			role_master_ff <= wdata[MASTER_BIT];
	end
	sequence ctrl_wr;
		wr_en && addr == CTRL_OFS && !scl_oe_n;
	endsequence
	// Line sits low through the filter delay before the pull
	wait_on_fall_a: assert property ($fell(scl_oe_n) |-> !scl_in && !$past(scl_in, 3))
		else $error("wait off fall");
	wait_holds_a: assert property ($rose(scl_oe_n) |-> $past(wr_en) || $past(wr_en, 2))
		else $error("wait dropped");
	shift_rel_a: assert property (wr_en && addr == SHIFT_OFS && !scl_oe_n |-> ##2 scl_oe_n)
		else $error("shift no release");
	wrel_rel_a: assert property (ctrl_wr ##0 wdata[WAIT_REL_BIT] |-> ##2 scl_oe_n)
		else $error("wrel no release");
	master_rel_a: assert property (ctrl_wr ##0 role_master_ff && |wdata[1:0] |-> ##2 scl_oe_n)
		else $error("trig no release");
	slave_trig_a: assert property (ctrl_wr ##0 !role_master_ff && !wdata[WAIT_REL_BIT]
		|-> ##2 !scl_oe_n)
		else $error("slave trig release");
	ack_on_low_a: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data edge in high");
	open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("drive not low");
	rd_gap_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
		else $error("rdata out of slot");
endmodule
bind bus_wait_ctrl bus_wait_ctrl_assertions u_chk (.mclk(mclk), .arst_n(arst_n), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .bus_event_interrupt(bus_event_interrupt));

// ===== bus_peer_model.sv
`timescale 1ns/10ps
module bus_peer_model
(
	input  wire logic scl_oe_n,
	input  wire logic sda_oe_n,
	output wire logic scl_line,
	output wire logic sda_line
);
	logic scl_drv = 1'b1;
	logic sda_drv = 1'b1;
	int   wait_at = 0;
	logic ack_seen = 1'b0;
	// Pull-ups win only when nobody pulls
	assign scl_line = scl_drv & scl_oe_n;
	assign sda_line = sda_drv & sda_oe_n;
	task automatic start_cond();
	begin
		sda_drv = 1'b1;
		#110 scl_drv = 1'b1;
		wait (scl_line === 1'b1);
		#200 sda_drv = 1'b0;
		#200 scl_drv = 1'b0;
		#280;
	end
	endtask
	task automatic send_byte(input logic [7:0] b);
		int i;
	begin
		wait_at = 0;
		for (i = 1; i <= 9; i++)
		begin
			sda_drv = (i == 9) ? 1'b1 : b[8 - i];
			#20 scl_drv = 1'b1;
			// Step off the mclk edge that lets the clock go
			if (scl_oe_n === 1'b0)
				@(posedge scl_oe_n) #10;
			wait (scl_line === 1'b1);
			#100 ack_seen = (sda_line === 1'b0);
			scl_drv = 1'b0;
			#280;
			if (wait_at == 0 && scl_oe_n === 1'b0)
				wait_at = i;
		end
	end
	endtask
	task automatic stop_cond();
	begin
		sda_drv = 1'b0;
		#20 scl_drv = 1'b1;
		wait (scl_line === 1'b1);
		#200 sda_drv = 1'b1;
		#400;
	end
	endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import bus_wait_pkg::*;
	typedef struct {
		logic [7:0] ctrl;
		logic [7:0] adr;
		int         aw;
		int         ak;
		logic [7:0] dat;
		int         dw;
		logic [2:0] rofs;
		logic [7:0] rval;
		logic       trig;
	} row_s;
	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rdata;
	logic [7:0] v;
	logic       scl_oe_n;
	logic       sda_oe_n;
	logic       bus_event_interrupt;
	wire        scl_line;
	wire        sda_line;
	int         failures = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	row_s rows [6] = '{
		'{8'h00, 8'ha0, 9, 1, 8'h3c, 8, CTRL_OFS, 8'h24, 1'b1},
		'{8'h0c, 8'ha0, 9, 1, 8'h5a, 9, SHIFT_OFS, 8'hff, 1'b0},
		'{8'h00, 8'h00, 8, 2, 8'h00, 0, CTRL_OFS, 8'h20, 1'b0},
		'{8'h00, 8'h22, 0, 0, 8'h00, 0, CTRL_OFS, 8'h20, 1'b0},
		'{8'h40, 8'hc4, 9, 2, 8'h00, 0, CTRL_OFS, 8'h41, 1'b0},
		'{8'h48, 8'hc4, 9, 2, 8'h00, 0, CTRL_OFS, 8'h42, 1'b0}};
	bus_wait_ctrl u_dut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .scl_in(scl_line), .scl_out(),
		.scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(), .sda_oe_n(sda_oe_n),
		.bus_event_interrupt(bus_event_interrupt));
	bus_peer_model u_peer (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_line(scl_line),
		.sda_line(sda_line));
	always #25 mclk = ~mclk;
	task automatic report_and_stop();
	begin
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			report_and_stop();
		end
	end
	task automatic chk(input logic ok, input string m);
	begin
		samples_checked++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("[FAIL] %0t %s", $time, m);
		end
	end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
	begin
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	end
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
	begin
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		d = rdata;
	end
	endtask
	task automatic watch(input row_s r, input logic [7:0] sh);
		int n;
		logic [7:0] q;
	begin
		for (n = 0; n < 120 && scl_oe_n !== 1'b0; n++)
			@(negedge mclk);
		if (n < 120)
		begin
			repeat (2) @(negedge mclk);
			chk(bus_event_interrupt === 1'b1, "no irq");
			rd(SHIFT_OFS, q);
			chk(q === sh, "shift capture");
			rd(IRQ_STAT_OFS, q);
			chk(q === 8'h01, "byte event");
			if (r.trig)
			begin
				wr(CTRL_OFS, 8'h02);
				repeat (2) @(negedge mclk);
				chk(scl_oe_n === 1'b0, "slave trig freed");
			end
			// Ack level set with the release
			wr(r.rofs, r.rval);
			repeat (2) @(negedge mclk);
			chk(scl_oe_n === 1'b1, "not released");
		end
	end
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		chk(scl_oe_n === 1'b1 && sda_oe_n === 1'b1 && bus_event_interrupt === 1'b0, "reset");
		arst_n <= 1'b1;
		rd(SHIFT_OFS, v);
		chk(v === SHIFT_RST, "shift reset");
		rd(3'h7, v);
		chk(v === 8'h00, "unmapped");
		wr(OWN_OFS, 8'ha0);
		wr(IRQ_MASK_OFS, 8'h03);
		foreach (rows[i])
		begin
			wr(CTRL_OFS, rows[i].ctrl);
			// A master sends its own address byte from the shift register
			if (rows[i].ctrl[MASTER_BIT])
				wr(SHIFT_OFS, rows[i].adr);
			u_peer.start_cond();
			fork
				u_peer.send_byte(rows[i].adr);
				watch(rows[i], rows[i].adr);
			join
			chk(u_peer.wait_at == rows[i].aw, "addr wait");
			if (rows[i].ak != 2)
				chk(u_peer.ack_seen === rows[i].ak[0], "addr ack");
			if (rows[i].dw != 0)
			begin
				fork
					u_peer.send_byte(rows[i].dat);
					watch(rows[i], rows[i].dat);
				join
				chk(u_peer.wait_at == rows[i].dw, "data wait");
				chk(u_peer.ack_seen === 1'b1, "data ack");
			end
			u_peer.stop_cond();
			rd(STAT_OFS, v);
			chk(v[STAT_STOP_BIT] === 1'b1, "stop flag");
			rd(IRQ_STAT_OFS, v);
			chk(v === 8'h00, "stray event");
		end
		wr(CTRL_OFS, 8'h10);
		u_peer.start_cond();
		fork
			u_peer.send_byte(8'ha0);
			watch(rows[1], 8'ha0);
		join
		wr(IRQ_MASK_OFS, 8'h02);
		u_peer.start_cond();
		u_peer.send_byte(8'h22);
		chk(u_peer.wait_at == 0 && bus_event_interrupt === 1'b0, "restart");
		rd(IRQ_STAT_OFS, v);
		chk(v === 8'h01, "restart event");
		rd(STAT_OFS, v);
		chk(v[STAT_RESTART_BIT] === 1'b1, "restart flag");
		u_peer.stop_cond();
		chk(bus_event_interrupt === 1'b1, "stop irq");
		rd(IRQ_STAT_OFS, v);
		chk(v === 8'h02, "stop event");
		repeat (2) @(negedge mclk);
		chk(bus_event_interrupt === 1'b0, "irq clear");
		report_and_stop();
	end
endmodule
